// ---- hw/ip_src_map.svh ----
`ifndef IP_SRC_MAP_SVH
`define IP_SRC_MAP_SVH

// ****************************************
// Register byte offsets (low address byte)
// ****************************************
`define OFS_ADDR_FIRST  8'h00
`define OFS_ADDR_SECOND 8'h04
`define OFS_ADDR_THIRD  8'h08
`define OFS_ADDR_FOURTH 8'h0C
`define OFS_MASK        8'h10
`define OFS_GATEWAY     8'h14
`define OFS_CFG_CTRL    8'h18
`define OFS_STATUS      8'h1C
`define OFS_IRQ_MASK    8'h20
`define OFS_SOURCE      8'h24
`define OFS_RES_ADDR    8'h28
`define OFS_RES_MASK    8'h2C
`define OFS_RES_GATEWAY 8'h30

// ****************************************
// Reset values
// ****************************************
`define RST_ADDR_FIRST  8'hC0
`define RST_ADDR_SECOND 8'hA8
`define RST_ADDR_THIRD  8'h01
`define RST_ADDR_FOURTH 8'h01
`define RST_MASK        32'hFFFFFF00
`define RST_GATEWAY     32'h00000000
`define RST_CFG_CTRL    2'h2

// ****************************************
// Source select codes and switch positions
// ****************************************
`define CFG_PARAM       2'h0
`define CFG_DHCP        2'h2
`define SW_DEFAULT      4'h0
`define SW_FIXED        4'hF

// ****************************************
// Fixed fallback identity
// ****************************************
`define FIX_ADDR        32'hC0A80101
`define FIX_MASK        32'hFFFFFF00
`define FIX_GATEWAY     32'h00000000

// ****************************************
// Status bit positions
// ****************************************
`define ST_DUP_ADDR     0
`define ST_LEASE        1
`define ST_WIDTH        2

`endif

// ---- hw/ip_src_pkg.sv ----
package ip_src_pkg;

	// Power-on sampling phase
	typedef enum logic {
		PH_SAMPLE,
		PH_RUN
	} phase_e;

	// Where the active identity comes from
	typedef enum logic [1:0] {
		SRC_PARAM,
		SRC_SWITCH,
		SRC_FIXED,
		SRC_DHCP
	} src_e;

	// Address, mask and gateway, first octet in the top byte
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] mask;
		logic [31:0] gw;
	} net_cfg_s;

	// Captured AHB address phase
	typedef struct packed {
		logic       act;
		logic       write;
		logic [7:0] ofs;
	} ahb_dph_s;

	// Assemble four octets, first octet most significant
	function automatic logic [31:0] pack_octets(input logic [7:0] o1, input logic [7:0] o2,
		input logic [7:0] o3, input logic [7:0] o4);
		pack_octets = {o1, o2, o3, o4};
	endfunction

endpackage

// ---- hw/net_cfg_resolver.sv ----
`timescale 1ns/10ps
`include "ip_src_map.svh"

// Combinational choice of the active identity from the sampled switch
module net_cfg_resolver (
	// Power-on selection inputs
	input  wire logic [3:0]          sw,
	input  wire logic [1:0]          cfg_ctrl,
	// Stored parameters
	input  wire logic [7:0]          oct1,
	input  wire logic [7:0]          oct2,
	input  wire logic [7:0]          oct3,
	input  wire logic [7:0]          oct4,
	input  wire logic [31:0]         mask,
	input  wire logic [31:0]         gw,
	// Server lease
	input  wire logic                lease_valid,
	input  wire ip_src_pkg::net_cfg_s lease,
	// Result
	output ip_src_pkg::net_cfg_s     res,
	output ip_src_pkg::src_e         src,
	output logic                     res_valid
);

	// Fixed position beats everything, switch digit beats the source select
	always_comb begin
		res       = '0;
		src       = ip_src_pkg::SRC_PARAM;
		res_valid = 1'b1;
		if (sw == `SW_FIXED) begin
			res.addr = `FIX_ADDR;
			res.mask = `FIX_MASK;
			res.gw   = `FIX_GATEWAY;
			src      = ip_src_pkg::SRC_FIXED;
		end else if (sw != `SW_DEFAULT) begin
			res.addr = ip_src_pkg::pack_octets(oct1, oct2, oct3, {4'h0, sw});
			res.mask = mask;
			res.gw   = gw;
			src      = ip_src_pkg::SRC_SWITCH;
		end else if (cfg_ctrl == `CFG_DHCP) begin
			// Nothing is mixed in: no lease means no identity yet
			res       = lease_valid ? lease : '0;
			src       = ip_src_pkg::SRC_DHCP;
			res_valid = lease_valid;
		end else begin
			res.addr = ip_src_pkg::pack_octets(oct1, oct2, oct3, oct4);
			res.mask = mask;
			res.gw   = gw;
		end
	end

endmodule

// ---- hw/ip_addr_source_select.sv ----
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "ip_src_map.svh"

// Contract
// - Switch 1..E: octets 1-3 stored, octet 4 from switch, stored mask/gateway.
// - Switch F: 192.168.1.1, 255.255.255.0, 0.0.0.0 regardless of anything else.
// - Switch 0: source select 0 uses stored values, 2 uses server; never mixed.
// - Any nonzero switch forces source select to stored parameters.
// - Switch is one hex digit; 1..14 becomes the fourth octet value.
// - First three octets stored separately, 0..255, defaults 192, 168, 1.
// - Switch position zero is the default and enables source select.
// - Switch sampled only at power-up; later changes ignored until next power-up.
// - Address conflict reported as a duplicate address error.
// - Source select accepts only 0 or 2; default is 2.
// - Mask defaults 255.255.255.0, gateway 0.0.0.0, each octet 0..255.
// - Server-supplied identity is discarded on power loss.
module ip_addr_source_select (
	// Clock and power-on reset
	input  wire logic                 clk,
	input  wire logic                 resetn,
	// AHB-Lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	// Rotary address switch
	input  wire logic [3:0]           addr_switch_low_digit,
	// Server lease from the network stack
	input  wire logic                 lease_valid,
	input  wire ip_src_pkg::net_cfg_s lease,
	// Conflict report from the network stack
	input  wire logic                 conflict_seen,
	// Resolved identity, duplicate address error and interrupt
	output ip_src_pkg::net_cfg_s      net_cfg,
	output logic                      net_cfg_valid,
	output ip_src_pkg::src_e          net_src,
	output logic                      duplicate_addr_error,
	output logic                      irq
);

	// ****************************************
	// State
	// ****************************************
	ip_src_pkg::phase_e   phase_q;
	logic [3:0]           switch_q;
	logic [7:0]           oct1_q;
	logic [7:0]           oct2_q;
	logic [7:0]           oct3_q;
	logic [7:0]           oct4_q;
	logic [31:0]          mask_q;
	logic [31:0]          gw_q;
	logic [1:0]           cfg_q;
	logic [`ST_WIDTH-1:0] status_q;
	logic [`ST_WIDTH-1:0] status_d;
	logic [`ST_WIDTH-1:0] irq_mask_q;
	logic                 lease_valid_q;
	ip_src_pkg::net_cfg_s lease_q;
	ip_src_pkg::ahb_dph_s dph_q;
	logic [31:0]          rdata_q;
	ip_src_pkg::net_cfg_s res;
	ip_src_pkg::src_e     res_src;
	logic                 res_valid;
	logic                 wr;
	logic                 addr_ok;
	logic                 lease_take;

	// Register offset match in the data phase
	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = wr && (dph_q.ofs == ofs);
	endfunction

	// ****************************************
	// Bus slave
	// ****************************************

	// Zero wait state, every access answers OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;
	// Only aligned words inside the first 256 bytes are live
	assign addr_ok   = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'b00) && (hsize == 3'b010);
	assign wr        = dph_q.act && dph_q.write;

	// Address phase capture
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dph_q <= '0;
		end else if (hready) begin
			dph_q.act   <= hsel && htrans[1] && addr_ok;
			dph_q.write <= hwrite;
			dph_q.ofs   <= haddr[7:0];
		end
	end

	// Read data latched at the address phase, so it stands through the data phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= '0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			rdata_q <= '0;
			if (addr_ok) begin
				unique case (haddr[7:0])
					`OFS_ADDR_FIRST:  rdata_q <= {24'h0, oct1_q};
					`OFS_ADDR_SECOND: rdata_q <= {24'h0, oct2_q};
					`OFS_ADDR_THIRD:  rdata_q <= {24'h0, oct3_q};
					`OFS_ADDR_FOURTH: rdata_q <= {24'h0, oct4_q};
					`OFS_MASK:        rdata_q <= mask_q;
					`OFS_GATEWAY:     rdata_q <= gw_q;
					`OFS_CFG_CTRL:    rdata_q <= {30'h0, cfg_q};
					`OFS_STATUS:      rdata_q <= {30'h0, status_q};
					`OFS_IRQ_MASK:    rdata_q <= {30'h0, irq_mask_q};
					`OFS_SOURCE:      rdata_q <= {24'h0, net_cfg_valid, 1'b0, net_src, switch_q};
					`OFS_RES_ADDR:    rdata_q <= net_cfg.addr;
					`OFS_RES_MASK:    rdata_q <= net_cfg.mask;
					`OFS_RES_GATEWAY: rdata_q <= net_cfg.gw;
					default:          rdata_q <= '0;
				endcase
			end
		end
	end

	// ****************************************
	// Power-on switch sampling
	// ****************************************

	// One capture after reset release; a live switch change is never seen
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_q  <= ip_src_pkg::PH_SAMPLE;
			switch_q <= `SW_DEFAULT;
		end else if (phase_q == ip_src_pkg::PH_SAMPLE) begin
			phase_q  <= ip_src_pkg::PH_RUN;
			switch_q <= addr_switch_low_digit;
		end
	end

	// ****************************************
	// Stored parameters
	// ****************************************

	// Address octets, full 0..255 range each
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			oct1_q <= `RST_ADDR_FIRST;
			oct2_q <= `RST_ADDR_SECOND;
			oct3_q <= `RST_ADDR_THIRD;
			oct4_q <= `RST_ADDR_FOURTH;
		end else begin
			if (wr_hit(`OFS_ADDR_FIRST)) oct1_q <= hwdata[7:0];
			if (wr_hit(`OFS_ADDR_SECOND)) oct2_q <= hwdata[7:0];
			if (wr_hit(`OFS_ADDR_THIRD)) oct3_q <= hwdata[7:0];
			if (wr_hit(`OFS_ADDR_FOURTH)) oct4_q <= hwdata[7:0];
		end
	end

	// Mask and gateway, one octet per byte
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mask_q <= `RST_MASK;
			gw_q   <= `RST_GATEWAY;
		end else begin
			if (wr_hit(`OFS_MASK)) mask_q <= hwdata;
			if (wr_hit(`OFS_GATEWAY)) gw_q <= hwdata;
		end
	end

	// Source select: illegal codes are dropped, nonzero switch pins it to 0
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q <= `RST_CFG_CTRL;
		end else if (phase_q == ip_src_pkg::PH_SAMPLE) begin
			if (addr_switch_low_digit != `SW_DEFAULT) cfg_q <= `CFG_PARAM;
		end else if (switch_q != `SW_DEFAULT) begin
			cfg_q <= `CFG_PARAM;
		end else if (wr_hit(`OFS_CFG_CTRL) && hwdata[31:2] == 30'h0 &&
			(hwdata[1:0] == `CFG_PARAM || hwdata[1:0] == `CFG_DHCP)) begin
			cfg_q <= hwdata[1:0];
		end
	end

	// ****************************************
	// Server lease
	// ****************************************

	// Held in volatile flops only, so power loss drops it
	assign lease_take = lease_valid && (phase_q == ip_src_pkg::PH_RUN) &&
		(switch_q == `SW_DEFAULT) && (cfg_q == `CFG_DHCP);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lease_valid_q <= 1'b0;
			lease_q       <= '0;
		end else if (lease_take) begin
			lease_valid_q <= 1'b1;
			lease_q       <= lease;
		end else if (cfg_q != `CFG_DHCP) begin
			lease_valid_q <= 1'b0;
		end
	end

	// ****************************************
	// Resolution
	// ****************************************

	net_cfg_resolver net_cfg_resolver_i (
		.sw          (switch_q),
		.cfg_ctrl    (cfg_q),
		.oct1        (oct1_q),
		.oct2        (oct2_q),
		.oct3        (oct3_q),
		.oct4        (oct4_q),
		.mask        (mask_q),
		.gw          (gw_q),
		.lease_valid (lease_valid_q),
		.lease       (lease_q),
		.res         (res),
		.src         (res_src),
		.res_valid   (res_valid)
	);

	// Outputs registered; nothing is offered before the switch is sampled
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			net_cfg       <= '0;
			net_cfg_valid <= 1'b0;
			net_src       <= ip_src_pkg::SRC_PARAM;
		end else if (phase_q == ip_src_pkg::PH_RUN) begin
			net_cfg       <= res;
			net_cfg_valid <= res_valid;
			net_src       <= res_src;
		end
	end

	// ****************************************
	// Events and interrupt
	// ****************************************

	// Write one to clear; an event in the same cycle wins
	always_comb begin
		status_d = status_q;
		if (wr_hit(`OFS_STATUS)) status_d = status_q & ~hwdata[`ST_WIDTH-1:0];
		if (conflict_seen) status_d[`ST_DUP_ADDR] = 1'b1;
		if (lease_take) status_d[`ST_LEASE] = 1'b1;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_q   <= '0;
			irq_mask_q <= '0;
		end else begin
			status_q <= status_d;
			if (wr_hit(`OFS_IRQ_MASK)) irq_mask_q <= hwdata[`ST_WIDTH-1:0];
		end
	end

	assign irq                  = |(status_q & irq_mask_q);
	assign duplicate_addr_error = status_q[`ST_DUP_ADDR];

	// ****************************************
	// Assertions
	// ****************************************

	// Plain helper nets, so $past only ever looks at a signal
	logic clr_hit;
	logic irq_next;
	assign clr_hit  = wr_hit(`OFS_STATUS);
	// Mask as it will stand after this edge, so a mask write is not a false rise
	assign irq_next = |(status_d &
		(wr_hit(`OFS_IRQ_MASK) ? hwdata[`ST_WIDTH-1:0] : irq_mask_q));

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_running;
		phase_q == ip_src_pkg::PH_RUN;
	endsequence

	sequence s_switch_digit;
		s_running ##0 (switch_q != `SW_DEFAULT) && (switch_q != `SW_FIXED);
	endsequence

	sequence s_param_mode;
		s_running ##0 (switch_q == `SW_DEFAULT) && (cfg_q == `CFG_PARAM);
	endsequence

	switch_frozen_a: assert property (s_running |=> $stable(switch_q))
		else $error("switch sample changed after power-up");

	fixed_identity_a: assert property ((s_running ##0 switch_q == `SW_FIXED) |=>
		net_cfg.addr == `FIX_ADDR && net_cfg.mask == `FIX_MASK &&
		net_cfg.gw == `FIX_GATEWAY && net_cfg_valid)
		else $error("fixed switch position gave wrong identity");

	switch_octet_a: assert property (s_switch_digit |=>
		net_cfg.addr == {$past(oct1_q), $past(oct2_q), $past(oct3_q), 4'h0, $past(switch_q)} &&
		net_cfg.mask == $past(mask_q))
		else $error("switch digit not placed in fourth octet");

	forced_param_a: assert property ((s_running ##0 switch_q != `SW_DEFAULT) |->
		cfg_q == `CFG_PARAM)
		else $error("source select not forced with switch set");

	cfg_legal_a: assert property (cfg_q == `CFG_PARAM || cfg_q == `CFG_DHCP)
		else $error("source select holds an illegal code");

	param_source_a: assert property (s_param_mode |=>
		net_cfg.addr == {$past(oct1_q), $past(oct2_q), $past(oct3_q), $past(oct4_q)} &&
		net_cfg.gw == $past(gw_q) && net_src == ip_src_pkg::SRC_PARAM)
		else $error("stored parameters not used in parameter mode");

	dhcp_source_a: assert property ((s_running ##0 switch_q == `SW_DEFAULT &&
		cfg_q == `CFG_DHCP) |=> net_cfg_valid == $past(lease_valid_q) &&
		(!net_cfg_valid || net_cfg == $past(lease_q)))
		else $error("server identity mixed or wrongly flagged");

	lease_volatile_a: assert property (phase_q == ip_src_pkg::PH_SAMPLE |->
		!lease_valid_q && !net_cfg_valid)
		else $error("lease survived a power cycle");

	conflict_flag_a: assert property (conflict_seen |=>
		duplicate_addr_error [*2] or (duplicate_addr_error ##1 $past(clr_hit)))
		else $error("address conflict not reported");

	irq_level_a: assert property ($rose(irq) |-> $past(irq_next))
		else $error("interrupt rose without a masked event");

endmodule

// ---- tb/net_partner.sv ----
`timescale 1ns/10ps

// ****************************************
// Rotary switch and address server model
// ****************************************
module net_partner (
	// Clock
	input  wire logic                 clk,
	// Toward the block
	output logic      [3:0]           addr_switch_low_digit,
	output logic                      lease_valid,
	output ip_src_pkg::net_cfg_s      lease,
	output logic                      conflict_seen
);
	// Quiet at power-up
	initial begin
		addr_switch_low_digit = 4'h0;
		lease_valid = 1'b0;
		lease = '0;
		conflict_seen = 1'b0;
	end

	// Switch position; the block may only look at it at power-up
	task set_switch(input logic [3:0] pos);
		@(posedge clk);
		addr_switch_low_digit <= pos;
	endtask

	// One-cycle offer; data inverted after, so a stale copy never matches
	task offer(input ip_src_pkg::net_cfg_s cfg);
		@(posedge clk);
		lease_valid <= 1'b1;
		lease <= cfg;
		@(posedge clk);
		lease_valid <= 1'b0;
		lease <= ~cfg;
	endtask

	// Another node claims our address
	task claim_addr();
		@(posedge clk);
		conflict_seen <= 1'b1;
		@(posedge clk);
		conflict_seen <= 1'b0;
	endtask
endmodule

// ---- tb/tb_ip_addr_source_select.sv ----
`timescale 1ns/10ps
`include "ip_src_map.svh"

// ****************************************
// Bench for the address source selector
// ****************************************
module tb_ip_addr_source_select;
	logic                 clk;
	logic                 resetn;
	logic                 hsel;
	logic [31:0]          haddr;
	logic [1:0]           htrans;
	logic                 hwrite;
	logic [2:0]           hsize;
	logic [31:0]          hwdata;
	logic [31:0]          hrdata;
	logic                 hreadyout;
	logic                 hresp;
	logic [3:0]           sw;
	logic                 lease_valid;
	ip_src_pkg::net_cfg_s lease;
	logic                 conflict_seen;
	ip_src_pkg::net_cfg_s net_cfg;
	logic                 net_cfg_valid;
	ip_src_pkg::src_e     net_src;
	logic                 duplicate_addr_error;
	logic                 irq;
	int                   miscompares;
	int                   num_checks;
	int                   cycles;

	`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
		$display("ERROR %s expected %h seen %h", nm, exp, got); end end

	// ****************************************
	// Clock, watchdog and instances
	// ****************************************
	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	// Long enough for every test with a wide margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end

	ip_addr_source_select ip_addr_source_select_i (.clk(clk), .resetn(resetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.addr_switch_low_digit(sw), .lease_valid(lease_valid), .lease(lease),
		.conflict_seen(conflict_seen), .net_cfg(net_cfg), .net_cfg_valid(net_cfg_valid),
		.net_src(net_src), .duplicate_addr_error(duplicate_addr_error), .irq(irq));

	net_partner net_partner_i (.clk(clk), .addr_switch_low_digit(sw), .lease_valid(lease_valid),
		.lease(lease), .conflict_seen(conflict_seen));

	// ****************************************
	// Bus and power tasks
	// ****************************************
	// Single word transfer; waits on hready only, no cycle count assumed
	task ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, ofs};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task wr(input logic [7:0] ofs, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, ofs, d, x);
	endtask

	task rd_chk(input string nm, input logic [7:0] ofs, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'b0, ofs, 32'h0, d);
		`CHK(nm, exp, d)
		`CHK("hresp okay", 1'b0, hresp)
	endtask

	// Power cycle with the switch set beforehand
	task power_up(input logic [3:0] pos);
		net_partner_i.set_switch(pos);
		resetn <= 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_defaults();
		power_up(4'h0);
		rd_chk("octet1", `OFS_ADDR_FIRST, 32'h000000C0);
		rd_chk("octet2", `OFS_ADDR_SECOND, 32'h000000A8);
		rd_chk("octet3", `OFS_ADDR_THIRD, 32'h00000001);
		rd_chk("octet4", `OFS_ADDR_FOURTH, 32'h00000001);
		rd_chk("irq mask", `OFS_IRQ_MASK, 32'h00000000);
		rd_chk("mask", `OFS_MASK, 32'hFFFFFF00);
		rd_chk("gateway", `OFS_GATEWAY, 32'h00000000);
		rd_chk("source", `OFS_CFG_CTRL, 32'h00000002);
		rd_chk("unmapped", 8'h40, 32'h00000000);
		`CHK("valid no lease", 1'b0, net_cfg_valid)
		$display("test defaults done");
	endtask

	task t_dhcp();
		net_partner_i.offer({32'h0A000005, 32'hFFFF0000, 32'h0A000001});
		repeat (3) @(posedge clk);
		`CHK("lease cfg", {32'h0A000005, 32'hFFFF0000, 32'h0A000001}, net_cfg)
		`CHK("lease src", ip_src_pkg::SRC_DHCP, net_src)
		`CHK("lease valid", 1'b1, net_cfg_valid)
		wr(`OFS_CFG_CTRL, 32'h3);
		rd_chk("bad source", `OFS_CFG_CTRL, 32'h00000002);
		wr(`OFS_CFG_CTRL, 32'h0);
		repeat (3) @(posedge clk);
		`CHK("param cfg", {32'hC0A80101, 32'hFFFFFF00, 32'h0}, net_cfg)
		`CHK("param src", ip_src_pkg::SRC_PARAM, net_src)
		wr(`OFS_CFG_CTRL, 32'h2);
		net_partner_i.offer({32'h0A000007, 32'hFFFF0000, 32'h0A000001});
		repeat (2) @(posedge clk);
		`CHK("lease held", 32'h0A000007, net_cfg.addr)
		power_up(4'h0);
		`CHK("lease dropped", 1'b0, net_cfg_valid)
		$display("test dhcp done");
	endtask

	task t_switch();
		for (int s = 1; s <= 14; s++) begin
			power_up(s[3:0]);
			`CHK("switch addr", {24'hC0A801, 4'h0, s[3:0]}, net_cfg.addr)
			`CHK("switch mask", 32'hFFFFFF00, net_cfg.mask)
			`CHK("switch src", ip_src_pkg::SRC_SWITCH, net_src)
			rd_chk("forced source", `OFS_CFG_CTRL, 32'h00000000);
		end
		wr(`OFS_CFG_CTRL, 32'h2);
		rd_chk("source locked", `OFS_CFG_CTRL, 32'h00000000);
		net_partner_i.set_switch(4'h3);
		repeat (4) @(posedge clk);
		`CHK("switch frozen", 32'hC0A8010E, net_cfg.addr)
		$display("test switch done");
	endtask

	task t_fixed();
		power_up(4'hF);
		wr(`OFS_MASK, 32'hFFFF0000);
		wr(`OFS_ADDR_FIRST, 32'h0A);
		net_partner_i.offer({32'h0A000005, 32'hFFFF0000, 32'h0A000001});
		repeat (3) @(posedge clk);
		`CHK("fixed cfg", {32'hC0A80101, 32'hFFFFFF00, 32'h0}, net_cfg)
		`CHK("fixed src", ip_src_pkg::SRC_FIXED, net_src)
		rd_chk("fixed res addr", `OFS_RES_ADDR, 32'hC0A80101);
		rd_chk("fixed res mask", `OFS_RES_MASK, 32'hFFFFFF00);
		rd_chk("fixed res gw", `OFS_RES_GATEWAY, 32'h00000000);
		rd_chk("fixed source reg", `OFS_SOURCE, 32'h000000AF);
		rd_chk("fixed forced sel", `OFS_CFG_CTRL, 32'h00000000);
		power_up(4'h0);
		$display("test fixed done");
	endtask

	task t_conflict();
		net_partner_i.claim_addr();
		repeat (2) @(posedge clk);
		`CHK("dup flag", 1'b1, duplicate_addr_error)
		`CHK("irq masked", 1'b0, irq)
		wr(`OFS_IRQ_MASK, 32'h1);
		@(posedge clk);
		`CHK("irq on", 1'b1, irq)
		rd_chk("status", `OFS_STATUS, 32'h00000001);
		wr(`OFS_STATUS, 32'h1);
		@(posedge clk);
		`CHK("dup cleared", 1'b0, duplicate_addr_error)
		`CHK("irq off", 1'b0, irq)
		$display("test conflict done");
	endtask

	// ****************************************
	// Verdict and main sequence
	// ****************************************
	task results();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		miscompares = 0;
		num_checks = 0;
		cycles = 0;
		t_defaults();
		t_dhcp();
		t_switch();
		t_fixed();
		t_conflict();
		results();
	end
endmodule
